// file: hdl/cbt_consts.svh
/*
 constants for the bit, transfer and control execution block: flag positions,
 register-file indices, cycle counts, the top io address and the flag reset value.
 assumes it is included by bare name from the modules.
*/
// What this block does
// - rotate right puts carry in bit 7
// - flag set or clear touches only its flag
// - overflow set and clear drive V
// - bit-to-flag copies register bit into T
// - flag-to-bit writes T into register bit
// - interrupt on and off drive I
// - indirect load then post-increment pointer, two cycles
// - pre-decrement pointer then indirect load, two cycles
// - displacement load leaves pointer alone, two cycles
// - indirect store forms take two cycles
// - direct read loads register, two cycles
// - direct write stores register, two cycles
// - program memory read into R0 or Rd, three cycles
// - push writes register to stack, two cycles
// - pull reads stack top, two cycles
// - debug halt only signals debug system
// - io bit set writes its bit alone, io bit clear writes back the read byte less its bit
`ifndef CBT_CONSTS_SVH
`define CBT_CONSTS_SVH
`define CBT_FLAG_C      3'd0
`define CBT_FLAG_Z      3'd1
`define CBT_FLAG_N      3'd2
`define CBT_FLAG_V      3'd3
`define CBT_FLAG_S      3'd4
`define CBT_FLAG_H      3'd5
`define CBT_FLAG_T      3'd6
`define CBT_FLAG_I      3'd7
`define CBT_REG_R0      5'h00
`define CBT_REG_XL      5'h1A
`define CBT_REG_YL      5'h1C
`define CBT_REG_ZL      5'h1E
`define CBT_CYC_ONE     2'd1
`define CBT_CYC_TWO     2'd2
`define CBT_CYC_THREE   2'd3
`define CBT_IO_BIT_TOP  5'h1F
`define CBT_STATUS_FLAGS_RESET  8'h00
`endif

// file: hdl/cbt_exec.sv
/*
 execution unit for rotate, flag, bit transfer, load/store, program memory,
 stack and debug halt operations. issues one operation when startOp and busy low.
 assumes memories answer read data on the cycle after the address strobe.
*/
`timescale 1ns/10ps
`default_nettype none
`include "cbt_consts.svh"
module cbt_exec (
   input  wire logic           clk,
   input  wire logic           rstn,
   input  wire logic           startOp,
   input  wire cbt_pkg::cbt_op_t opCode,
   input  wire cbt_pkg::cbt_ptr_t ptrSel,
   input  wire logic [4:0]     regD,
   input  wire logic [2:0]     bitSel,
   input  wire logic [5:0]     disp,
   input  wire logic [15:0]    directAddr,
   input  wire logic [4:0]     ioAddr,
   input  wire logic [7:0]     dmemRdData,
   input  wire logic [7:0]     pmemRdData,
   input  wire logic [7:0]     stackRdData,
   input  wire logic [7:0]     ioRdData,
   output logic                busy,
   output logic                done,
   output logic [7:0]          statusFlags,
   output logic [15:0]         dmemAddr,
   output logic                dmemRd,
   output logic                dmemWr,
   output logic [7:0]          dmemWrData,
   output logic [15:0]         pmemAddr,
   output logic                pmemRd,
   output logic                stackPush,
   output logic                stackPop,
   output logic [7:0]          stackWrData,
   output logic                ioWr,
   output logic [4:0]          ioWrAddr,
   output logic [7:0]          ioWrData,
   output logic                debugHalt
);
   cbt_pkg::cbt_state_t state_q;
   cbt_pkg::cbt_op_t    op_q;
   logic [4:0]  rd_q;
   logic [2:0]  bit_q;
   logic [1:0]  cyc_q;
   logic [1:0]  cycNeed;
   logic [7:0]  status_flags_q;
   logic        rfWr;
   logic [4:0]  rfWrAddr;
   logic [7:0]  rfWrData;
   logic        ptrWr;
   logic [4:0]  ptrIdx;
   logic [15:0] ptrNew;
   logic [7:0]  rfRd;
   logic [15:0] xP;
   logic [15:0] yP;
   logic [15:0] zP;
   logic [15:0] curPtr;
   logic [7:0]  rorRes;
   logic        accept;
   logic        isIssue;

   // cycle count per operation class
   function automatic logic [1:0] opCycles(input cbt_pkg::cbt_op_t op);
      case (op)
         cbt_pkg::CBT_OP_LPM_R0, cbt_pkg::CBT_OP_LPM,
         cbt_pkg::CBT_OP_LPM_INC:  opCycles = `CBT_CYC_THREE;
         cbt_pkg::CBT_OP_LD, cbt_pkg::CBT_OP_LD_INC, cbt_pkg::CBT_OP_LD_DEC, cbt_pkg::CBT_OP_LDD,
         cbt_pkg::CBT_OP_ST, cbt_pkg::CBT_OP_ST_INC, cbt_pkg::CBT_OP_ST_DEC, cbt_pkg::CBT_OP_STD,
         cbt_pkg::CBT_OP_LDS, cbt_pkg::CBT_OP_STS, cbt_pkg::CBT_OP_PUSH, cbt_pkg::CBT_OP_POP,
         cbt_pkg::CBT_OP_IO_SET, cbt_pkg::CBT_OP_IO_CLR: opCycles = `CBT_CYC_TWO;
         default:                  opCycles = `CBT_CYC_ONE;
      endcase
   endfunction : opCycles

   // pointer low-register index for a select
   function automatic logic [4:0] ptrBase(input cbt_pkg::cbt_ptr_t p);
      case (p)
         cbt_pkg::CBT_PTR_X: ptrBase = `CBT_REG_XL;
         cbt_pkg::CBT_PTR_Y: ptrBase = `CBT_REG_YL;
         default:            ptrBase = `CBT_REG_ZL;
      endcase
   endfunction : ptrBase

   assign accept  = startOp && state_q == cbt_pkg::CBT_ST_IDLE;
   assign isIssue = accept;
   assign busy    = state_q != cbt_pkg::CBT_ST_IDLE;
   assign cycNeed = opCycles(op_q);
   assign statusFlags = status_flags_q;

   cbt_regfile uRegs (
      .clk     (clk),
      .rstn    (rstn),
      .wrEn    (rfWr),
      .wrAddr  (rfWrAddr),
      .wrData  (rfWrData),
      .ptrWrEn (ptrWr),
      .ptrAddr (ptrIdx),
      .ptrData (ptrNew),
      .rdAddr  (accept ? regD : rd_q),
      .rdData  (rfRd),
      .xPtr    (xP),
      .yPtr    (yP),
      .zPtr    (zP)
   );

   // latch the operation; operand byte arrives on the next cycle from the regfile
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         op_q  <= cbt_pkg::CBT_OP_NONE;
         rd_q  <= 5'h00;
         bit_q <= 3'h0;
         ptrIdx <= `CBT_REG_ZL;
      end
      else if (accept)
      begin
         op_q  <= opCode;
         rd_q  <= (opCode == cbt_pkg::CBT_OP_LPM_R0) ? `CBT_REG_R0 : regD;
         bit_q <= bitSel;
         ptrIdx <= (opCode == cbt_pkg::CBT_OP_LPM || opCode == cbt_pkg::CBT_OP_LPM_INC ||
                    opCode == cbt_pkg::CBT_OP_LPM_R0) ? `CBT_REG_ZL : ptrBase(ptrSel);
      end
   end

   // sequencer: cyc_q starts at 1 in W1 and counts up until it reaches the op's cycle count, then back to idle
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state_q <= cbt_pkg::CBT_ST_IDLE;
         cyc_q   <= 2'd0;
      end
      else
      begin
         case (state_q)
            cbt_pkg::CBT_ST_IDLE:
               if (accept)
               begin
                  state_q <= cbt_pkg::CBT_ST_W1;
                  cyc_q   <= 2'd1;
               end
            cbt_pkg::CBT_ST_W1:
               if (cyc_q >= cycNeed)
                  state_q <= cbt_pkg::CBT_ST_IDLE;
               else
               begin
                  state_q <= cbt_pkg::CBT_ST_W2;
                  cyc_q   <= cyc_q + 2'd1;
               end
            cbt_pkg::CBT_ST_W2:
               if (cyc_q >= cycNeed)
                  state_q <= cbt_pkg::CBT_ST_IDLE;
               else
                  cyc_q <= cyc_q + 2'd1;
            default:
               state_q <= cbt_pkg::CBT_ST_IDLE;
         endcase
      end
   end

   // the op finishes on its last cycle; memory data sampled there
   always_comb
   begin
      done = busy && cyc_q >= cycNeed;
   end

   // selected pointer value, before any update
   always_comb
   begin
      case (ptrIdx)
         `CBT_REG_XL: curPtr = xP;
         `CBT_REG_YL: curPtr = yP;
         default:     curPtr = zP;
      endcase
   end

   assign rorRes = {status_flags_q[`CBT_FLAG_C], rfRd[7:1]};

   // memory strobes issued in the first busy cycle, data returns on the next cycle
   always_comb
   begin
      dmemAddr = curPtr;
      dmemRd = 1'b0;
      dmemWr = 1'b0;
      pmemRd = 1'b0;
      stackPush = 1'b0;
      stackPop = 1'b0;
      ioWr = 1'b0;
      if (state_q == cbt_pkg::CBT_ST_W1)
      begin
         case (op_q)
            cbt_pkg::CBT_OP_LD, cbt_pkg::CBT_OP_LD_INC: dmemRd = 1'b1;
            cbt_pkg::CBT_OP_LD_DEC:
            begin
               dmemRd   = 1'b1;
               dmemAddr = curPtr - 16'h0001;
            end
            cbt_pkg::CBT_OP_LDD:
            begin
               dmemRd   = 1'b1;
               dmemAddr = curPtr + {10'h000, disp};
            end
            cbt_pkg::CBT_OP_ST, cbt_pkg::CBT_OP_ST_INC: dmemWr = 1'b1;
            cbt_pkg::CBT_OP_ST_DEC:
            begin
               dmemWr   = 1'b1;
               dmemAddr = curPtr - 16'h0001;
            end
            cbt_pkg::CBT_OP_STD:
            begin
               dmemWr   = 1'b1;
               dmemAddr = curPtr + {10'h000, disp};
            end
            cbt_pkg::CBT_OP_LDS:
            begin
               dmemRd   = 1'b1;
               dmemAddr = directAddr;
            end
            cbt_pkg::CBT_OP_STS:
            begin
               dmemWr   = 1'b1;
               dmemAddr = directAddr;
            end
            cbt_pkg::CBT_OP_LPM_R0, cbt_pkg::CBT_OP_LPM, cbt_pkg::CBT_OP_LPM_INC: pmemRd = 1'b1;
            cbt_pkg::CBT_OP_PUSH: stackPush = 1'b1;
            cbt_pkg::CBT_OP_POP: stackPop = 1'b1;
            default: dmemRd = 1'b0;
         endcase
      end
      // io write lands on the last cycle; set writes only its bit, clear writes back ioRdData less that bit
      if (done && (op_q == cbt_pkg::CBT_OP_IO_SET || op_q == cbt_pkg::CBT_OP_IO_CLR))
         ioWr = 1'b1;
   end

   // io bit set: unlike a full read-modify-write, other flags are written as zero so
   // write-one-to-clear flags stay untouched; io bit clear writes back ioRdData with the bit cleared
   always_comb
   begin
      ioWrData = 8'h00;
      if (op_q == cbt_pkg::CBT_OP_IO_SET)
         ioWrData[bit_q] = 1'b1;
      else
         ioWrData = ioRdData & ~(8'h01 << bit_q);
   end
   assign ioWrAddr = (ioAddr <= `CBT_IO_BIT_TOP) ? ioAddr : `CBT_IO_BIT_TOP;
   assign pmemAddr = zP;
   assign dmemWrData = rfRd;
   assign stackWrData = rfRd;

   // debug halt: one pulse to the debug system, no architectural effect
   assign debugHalt = accept && opCode == cbt_pkg::CBT_OP_BREAK;

   // register file writes at completion
   always_comb
   begin
      rfWr = 1'b0;
      rfWrAddr = rd_q;
      rfWrData = rfRd;
      ptrWr = 1'b0;
      ptrNew = curPtr;
      if (done)
      begin
         case (op_q)
            cbt_pkg::CBT_OP_ROR: begin rfWr = 1'b1; rfWrData = rorRes; end
            cbt_pkg::CBT_OP_BLD: begin rfWr = 1'b1; rfWrData[bit_q] = status_flags_q[`CBT_FLAG_T]; end
            cbt_pkg::CBT_OP_LD, cbt_pkg::CBT_OP_LDD, cbt_pkg::CBT_OP_LDS:
               begin rfWr = 1'b1; rfWrData = dmemRdData; end
            cbt_pkg::CBT_OP_LD_INC: begin rfWr = 1'b1; rfWrData = dmemRdData; ptrWr = 1'b1;
               ptrNew = curPtr + 16'h0001; end
            cbt_pkg::CBT_OP_LD_DEC: begin rfWr = 1'b1; rfWrData = dmemRdData; ptrWr = 1'b1;
               ptrNew = curPtr - 16'h0001; end
            cbt_pkg::CBT_OP_ST_INC: begin ptrWr = 1'b1; ptrNew = curPtr + 16'h0001; end
            cbt_pkg::CBT_OP_ST_DEC: begin ptrWr = 1'b1; ptrNew = curPtr - 16'h0001; end
            cbt_pkg::CBT_OP_LPM_R0, cbt_pkg::CBT_OP_LPM:
               begin rfWr = 1'b1; rfWrData = pmemRdData; end
            cbt_pkg::CBT_OP_LPM_INC: begin rfWr = 1'b1; rfWrData = pmemRdData; ptrWr = 1'b1;
               ptrNew = curPtr + 16'h0001; end
            cbt_pkg::CBT_OP_POP: begin rfWr = 1'b1; rfWrData = stackRdData; end
            default: rfWr = 1'b0;
         endcase
      end
   end

   // status flags: each op changes only the bits it owns
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         status_flags_q <= `CBT_STATUS_FLAGS_RESET;
      else if (done)
      begin
         case (op_q)
            cbt_pkg::CBT_OP_ROR:
            begin
               status_flags_q[`CBT_FLAG_C] <= rfRd[0];
               status_flags_q[`CBT_FLAG_Z] <= rorRes == 8'h00;
               status_flags_q[`CBT_FLAG_N] <= rorRes[7];
               status_flags_q[`CBT_FLAG_V] <= rorRes[7] ^ rfRd[0];
               status_flags_q[`CBT_FLAG_S] <= rfRd[0];                              // N xor V
            end
            cbt_pkg::CBT_OP_FLAG_SET: status_flags_q[bit_q] <= 1'b1;
            cbt_pkg::CBT_OP_FLAG_CLR: status_flags_q[bit_q] <= 1'b0;
            cbt_pkg::CBT_OP_BST: status_flags_q[`CBT_FLAG_T] <= rfRd[bit_q];
            default: status_flags_q <= status_flags_q;
         endcase
      end
   end
endmodule : cbt_exec
`default_nettype wire

// file: hdl/cbt_pkg.sv
/*
 types for the execution block: operation codes, pointer selects, states.
 assumes the constants header is on the include path.
*/
package cbt_pkg;
   typedef enum logic [4:0] {
      CBT_OP_NONE, CBT_OP_ROR, CBT_OP_FLAG_SET, CBT_OP_FLAG_CLR, CBT_OP_BST, CBT_OP_BLD,
      CBT_OP_LD, CBT_OP_LD_INC, CBT_OP_LD_DEC, CBT_OP_LDD, CBT_OP_ST, CBT_OP_ST_INC,
      CBT_OP_ST_DEC, CBT_OP_STD, CBT_OP_LDS, CBT_OP_STS, CBT_OP_LPM_R0, CBT_OP_LPM,
      CBT_OP_LPM_INC, CBT_OP_PUSH, CBT_OP_POP, CBT_OP_BREAK, CBT_OP_IO_SET, CBT_OP_IO_CLR
   } cbt_op_t;
   typedef enum logic [1:0] {CBT_PTR_X = 2'h0, CBT_PTR_Y = 2'h1, CBT_PTR_Z = 2'h2} cbt_ptr_t;
   // gray sequence idle -> wait1 -> wait2
   typedef enum logic [1:0] {CBT_ST_IDLE = 2'b00, CBT_ST_W1 = 2'b01, CBT_ST_W2 = 2'b11} cbt_state_t;
endpackage : cbt_pkg

// file: hdl/cbt_regfile.sv
/*
 small register file: 32 bytes, one write port plus a word write for pointer
 updates, registered read port and combinational pointer taps.
 assumes a single clock and an asynchronous active-low reset.
*/
`timescale 1ns/10ps
`default_nettype none
`include "cbt_consts.svh"
module cbt_regfile (
   input  wire logic       clk,
   input  wire logic       rstn,
   input  wire logic       wrEn,
   input  wire logic [4:0] wrAddr,
   input  wire logic [7:0] wrData,
   input  wire logic       ptrWrEn,
   input  wire logic [4:0] ptrAddr,
   input  wire logic [15:0] ptrData,
   input  wire logic [4:0] rdAddr,
   output logic      [7:0] rdData,
   output logic      [15:0] xPtr,
   output logic      [15:0] yPtr,
   output logic      [15:0] zPtr
);
   logic [7:0] mem_q [32];

   // byte write wins over pointer write on the same index
   genvar g;
   generate
      for (g = 0; g < 32; g++)
      begin : gReg
         always_ff @(posedge clk or negedge rstn)
         begin
            if (!rstn)
               mem_q[g] <= 8'h00;
            else if (wrEn && wrAddr == 5'(g))
               mem_q[g] <= wrData;
            else if (ptrWrEn && ptrAddr == 5'(g))
               mem_q[g] <= ptrData[7:0];
            else if (ptrWrEn && ptrAddr + 5'h01 == 5'(g))
               mem_q[g] <= ptrData[15:8];
         end
      end
   endgenerate

   // registered read port
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         rdData <= 8'h00;
      else
         rdData <= mem_q[rdAddr];
   end

   // pointer pairs from high registers
   assign xPtr = {mem_q[`CBT_REG_XL + 5'h01], mem_q[`CBT_REG_XL]};
   assign yPtr = {mem_q[`CBT_REG_YL + 5'h01], mem_q[`CBT_REG_YL]};
   assign zPtr = {mem_q[`CBT_REG_ZL + 5'h01], mem_q[`CBT_REG_ZL]};
endmodule : cbt_regfile
`default_nettype wire

// file: test/cbt_exec_checker.sv
/*
 port-level assertions for the execution unit.
 assumes one clock, active-low async reset; bound onto cbt_exec below.
*/
`timescale 1ns/10ps
`default_nettype none
module cbt_exec_checker (
   input wire logic             clk,
   input wire logic             rstn,
   input wire logic             startOp,
   input wire cbt_pkg::cbt_op_t opCode,
   input wire logic [2:0]       bitSel,
   input wire logic [15:0]      directAddr,
   input wire logic [4:0]       ioAddr,
   input wire logic             busy,
   input wire logic             done,
   input wire logic [7:0]       statusFlags,
   input wire logic [15:0]      dmemAddr,
   input wire logic             dmemRd,
   input wire logic             dmemWr,
   input wire logic             pmemRd,
   input wire logic             stackPush,
   input wire logic             stackPop,
   input wire logic             ioWr,
   input wire logic [4:0]       ioWrAddr,
   input wire logic [7:0]       ioWrData,
   input wire logic             debugHalt
);
   // accept strobe; a request while busy is dropped without sign
   logic acc;
   assign acc = startOp && !busy;
   default clocking dc @(posedge clk); endclocking
   default disable iff (!rstn);
   property p_one;
      acc && opCode inside {cbt_pkg::CBT_OP_ROR, cbt_pkg::CBT_OP_BST, cbt_pkg::CBT_OP_BLD} |=> done && busy;
   endproperty
   a_one: assert property (p_one) else $error("single-cycle op late");
   property p_load;
      acc && opCode inside {cbt_pkg::CBT_OP_LD, cbt_pkg::CBT_OP_LD_INC, cbt_pkg::CBT_OP_LD_DEC,
         cbt_pkg::CBT_OP_LDD, cbt_pkg::CBT_OP_LDS} |=> (dmemRd && !done) ##1 done;
   endproperty
   a_load: assert property (p_load) else $error("load not two cycles");
   property p_store;
      acc && opCode inside {cbt_pkg::CBT_OP_ST, cbt_pkg::CBT_OP_ST_INC, cbt_pkg::CBT_OP_ST_DEC,
         cbt_pkg::CBT_OP_STD, cbt_pkg::CBT_OP_STS} |=> (dmemWr && !done) ##1 done;
   endproperty
   a_store: assert property (p_store) else $error("store not two cycles");
   property p_pmem;
      acc && opCode inside {cbt_pkg::CBT_OP_LPM_R0, cbt_pkg::CBT_OP_LPM, cbt_pkg::CBT_OP_LPM_INC}
         |=> pmemRd ##1 !done ##1 done;
   endproperty
   a_pmem: assert property (p_pmem) else $error("program read not three cycles");
   property p_stack;
      acc && opCode inside {cbt_pkg::CBT_OP_PUSH, cbt_pkg::CBT_OP_POP} |=> ((stackPush || stackPop) && !done) ##1 done;
   endproperty
   a_stack: assert property (p_stack) else $error("stack op not two cycles");
   // flags land on the edge that closes done, so look three edges on
   property p_flag;
      acc && opCode == cbt_pkg::CBT_OP_FLAG_SET |-> ##3 statusFlags == ($past(statusFlags, 3) | (8'h01 << $past(bitSel, 3)));
   endproperty
   a_flag: assert property (p_flag) else $error("flag set touched wrong bits");
   property p_direct;
      acc && opCode inside {cbt_pkg::CBT_OP_LDS, cbt_pkg::CBT_OP_STS} |=> dmemAddr == $past(directAddr);
   endproperty
   a_direct: assert property (p_direct) else $error("direct address wrong");
   property p_halt;
      acc && opCode == cbt_pkg::CBT_OP_BREAK |-> debugHalt ##1 (done && !dmemWr && !stackPush) ##1 !busy;
   endproperty
   a_halt: assert property (p_halt) else $error("halt pulse wrong");
   property p_io;
      acc && opCode == cbt_pkg::CBT_OP_IO_SET |-> ##2 ioWr && ioWrAddr == $past(ioAddr, 2)
         && ioWrData == (8'h01 << $past(bitSel, 2));
   endproperty
   a_io: assert property (p_io) else $error("io set wrote other bits");
   c_lpm: cover property (acc && opCode == cbt_pkg::CBT_OP_LPM_INC);
   c_dec: cover property (acc && opCode == cbt_pkg::CBT_OP_LD_DEC);
   c_ioc: cover property (acc && opCode == cbt_pkg::CBT_OP_IO_CLR);
endmodule : cbt_exec_checker
bind cbt_exec cbt_exec_checker chk_u (.*);
`default_nettype wire

// file: test/cbt_exec_tb_top.sv
/*
 bench for the execution unit: one task per scenario.
 assumes the memory model and bound checker are compiled before it.
*/
`timescale 1ns/10ps
`default_nettype none
module cbt_exec_tb_top;
   logic              clk, rstn, startOp, busy, done, dmemRd, dmemWr, pmemRd, stackPush, stackPop, ioWr, debugHalt;
   cbt_pkg::cbt_op_t  opCode;
   cbt_pkg::cbt_ptr_t ptrSel;
   logic [4:0]        regD, ioAddr, ioWrAddr;
   logic [2:0]        bitSel;
   logic [5:0]        disp;
   logic [15:0]       directAddr, dmemAddr, pmemAddr;
   logic [7:0]        dmemRdData, pmemRdData, stackRdData, ioRdData, statusFlags, dmemWrData, stackWrData, ioWrData, fl;
   int                fail_count, n_checks, nCyc;
   cbt_exec dut_u (.*);
   cbt_mem_model mem_u (.*);
   // 50 ns clock
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic test_done(input logic tmo);
      if (tmo) fail_count++;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : test_done
   // issue at a falling edge, count cycles to done, return after results land
   task automatic exec(input cbt_pkg::cbt_op_t op, input int cyc);
      opCode = op;
      startOp = 1'b1;
      @(negedge clk);
      startOp = 1'b0;
      nCyc = 1;
      while (done !== 1'b1)
      begin
         @(negedge clk);
         nCyc++;
         if (nCyc > 8) test_done(1'b1);
      end
      @(negedge clk);
      check(16'(nCyc), 16'(cyc));
   endtask : exec
   task automatic ldr(input logic [4:0] r, input logic [7:0] v);
      mem_u.dmem[8'hF0] = v;
      regD = r;
      directAddr = 16'h00F0;
      exec(cbt_pkg::CBT_OP_LDS, 2);
   endtask : ldr
   // registers are only visible by storing them out
   task automatic expr(input logic [4:0] r, input logic [7:0] e);
      regD = r;
      directAddr = 16'h00F1;
      exec(cbt_pkg::CBT_OP_STS, 2);
      check(mem_u.dmem[8'hF1], e);
   endtask : expr
   task automatic t_flags();
      fl = 8'h00;
      check(statusFlags, fl);
      for (int i = 0; i < 16; i++)
      begin
         bitSel = 3'(i);
         exec(i < 8 ? cbt_pkg::CBT_OP_FLAG_SET : cbt_pkg::CBT_OP_FLAG_CLR, 1);
         fl[i % 8] = (i < 8);
         check(statusFlags, fl);
      end
      $display("flags test done");
   endtask : t_flags
   task automatic ror1(input logic c, input logic [7:0] v, input logic [7:0] ev, input logic [3:0] ef);
      bitSel = 3'd0;
      exec(c ? cbt_pkg::CBT_OP_FLAG_SET : cbt_pkg::CBT_OP_FLAG_CLR, 1);
      ldr(5'h05, v);
      regD = 5'h05;
      exec(cbt_pkg::CBT_OP_ROR, 1);
      check(statusFlags[3:0], ef);
      expr(5'h05, ev);
   endtask : ror1
   task automatic t_bits();
      ldr(5'h03, 8'h20);
      bitSel = 3'd5;
      exec(cbt_pkg::CBT_OP_BST, 1);
      check(statusFlags[6], 1'b1);
      bitSel = 3'd4;
      exec(cbt_pkg::CBT_OP_BST, 1);
      check(statusFlags, 8'h00);
      bitSel = 3'd6;
      exec(cbt_pkg::CBT_OP_FLAG_SET, 1);
      ldr(5'h07, 8'hF0);
      bitSel = 3'd2;
      exec(cbt_pkg::CBT_OP_BLD, 1);
      check(statusFlags, 8'h40);
      expr(5'h07, 8'hF4);
      $display("bit test done");
   endtask : t_bits
   task automatic t_ptr();
      ldr(5'h1A, 8'hFF);
      ldr(5'h1B, 8'h00);
      mem_u.dmem[8'hFF] = 8'h5A;
      regD = 5'h08;
      ptrSel = cbt_pkg::CBT_PTR_X;
      exec(cbt_pkg::CBT_OP_LD_INC, 2);
      expr(5'h08, 8'h5A);
      expr(5'h1B, 8'h01);
      ldr(5'h1C, 8'h00);
      ldr(5'h1D, 8'h01);
      mem_u.dmem[8'hFF] = 8'h6B;
      regD = 5'h09;
      ptrSel = cbt_pkg::CBT_PTR_Y;
      exec(cbt_pkg::CBT_OP_LD_DEC, 2);
      expr(5'h09, 8'h6B);
      expr(5'h1C, 8'hFF);
      ldr(5'h1E, 8'h10);
      ldr(5'h1F, 8'h00);
      mem_u.dmem[8'h15] = 8'h7C;
      {disp, regD} = {6'd5, 5'h0A};
      ptrSel = cbt_pkg::CBT_PTR_Z;
      exec(cbt_pkg::CBT_OP_LDD, 2);
      expr(5'h0A, 8'h7C);
      expr(5'h1E, 8'h10);
      mem_u.dmem[8'h10] = 8'h3E;
      regD = 5'h0C;
      exec(cbt_pkg::CBT_OP_LD, 2);
      expr(5'h0C, 8'h3E);
      $display("pointer load test done");
   endtask : t_ptr
   task automatic st1(input cbt_pkg::cbt_op_t op, input logic [7:0] a);
      mem_u.dmem[a] = 8'h00;
      {disp, regD} = {6'd3, 5'h0A};
      exec(op, 2);
      check(mem_u.dmem[a], 8'h7C);
   endtask : st1
   task automatic t_rest();
      st1(cbt_pkg::CBT_OP_ST_INC, 8'h10);
      st1(cbt_pkg::CBT_OP_ST_DEC, 8'h10);
      st1(cbt_pkg::CBT_OP_STD, 8'h13);
      st1(cbt_pkg::CBT_OP_ST, 8'h10);
      regD = 5'h0B;
      exec(cbt_pkg::CBT_OP_LPM_R0, 3);
      expr(5'h00, 8'h2C);
      expr(5'h0B, 8'h00);
      exec(cbt_pkg::CBT_OP_LPM_INC, 3);
      expr(5'h0B, 8'h2C);
      expr(5'h1E, 8'h11);
      regD = 5'h0E;
      exec(cbt_pkg::CBT_OP_LPM, 3);
      expr(5'h0E, 8'h2D);
      regD = 5'h0B;
      fl = statusFlags;
      exec(cbt_pkg::CBT_OP_PUSH, 2);
      check(mem_u.stk[0], 8'h2C);
      regD = 5'h0D;
      exec(cbt_pkg::CBT_OP_POP, 2);
      expr(5'h0D, 8'h2C);
      check(statusFlags, fl);
      {mem_u.io[31], ioAddr, bitSel} = {8'h81, 5'h1F, 3'd3};
      exec(cbt_pkg::CBT_OP_IO_SET, 2);
      check({mem_u.ioLastAddr, mem_u.ioLast}, 13'h1F08);
      bitSel = 3'd7;
      exec(cbt_pkg::CBT_OP_IO_CLR, 2);
      check(mem_u.ioLast, 8'h01);
      opCode = cbt_pkg::CBT_OP_BREAK;
      startOp = 1'b1;
      #1 check(debugHalt, 1'b1);
      @(negedge clk);
      startOp = 1'b0;
      for (int i = 0; i < 8 && busy === 1'b1; i++) @(negedge clk);
      check(busy, 1'b0);
      $display("store, program, stack, io and halt test done");
   endtask : t_rest
   // reset for two cycles, then scenarios in turn
   initial
   begin
      {rstn, startOp, regD, bitSel, disp, directAddr, ioAddr, fail_count, n_checks} = '0;
      opCode = cbt_pkg::CBT_OP_NONE;
      ptrSel = cbt_pkg::CBT_PTR_X;
      repeat (2) @(negedge clk);
      rstn = 1'b1;
      @(negedge clk);
      t_flags();
      ror1(1'b1, 8'h81, 8'hC0, 4'h5);
      ror1(1'b0, 8'h01, 8'h00, 4'hB);
      ror1(1'b0, 8'h80, 8'h40, 4'h0);
      t_bits();
      t_ptr();
      t_rest();
      test_done(1'b0);
   end
endmodule : cbt_exec_tb_top
`default_nettype wire

// file: test/cbt_mem_model.sv
/*
 behavioural data, program, stack and io memories facing the execution unit.
 assumes read data is wanted one edge after the strobe and held.
*/
`timescale 1ns/10ps
`default_nettype none
module cbt_mem_model (
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic [15:0] dmemAddr,
   input  wire logic        dmemRd,
   input  wire logic        dmemWr,
   input  wire logic [7:0]  dmemWrData,
   output var  logic [7:0]  dmemRdData,
   input  wire logic [15:0] pmemAddr,
   input  wire logic        pmemRd,
   output var  logic [7:0]  pmemRdData,
   input  wire logic        stackPush,
   input  wire logic        stackPop,
   input  wire logic [7:0]  stackWrData,
   output var  logic [7:0]  stackRdData,
   input  wire logic [4:0]  ioAddr,
   input  wire logic        ioWr,
   input  wire logic [4:0]  ioWrAddr,
   input  wire logic [7:0]  ioWrData,
   output logic      [7:0]  ioRdData
);
   logic [7:0] dmem [256];
   logic [7:0] stk [16];
   logic [7:0] io [32];
   logic [3:0] sp;
   logic [7:0] ioLast;
   logic [4:0] ioLastAddr;
   // only 256 data bytes: higher addresses alias, so tests stay low
   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         {dmemRdData, pmemRdData, stackRdData, sp} <= '0;
      else
      begin
         if (dmemRd) dmemRdData <= dmem[dmemAddr[7:0]];
         if (dmemWr) dmem[dmemAddr[7:0]] <= dmemWrData;
         if (pmemRd) pmemRdData <= pmemAddr[7:0] ^ 8'h3C;
         if (stackPush) stk[sp] <= stackWrData;
         if (stackPush) sp <= sp + 4'h1;
         if (stackPop) stackRdData <= stk[sp - 4'h1];
         if (stackPop) sp <= sp - 4'h1;
         if (ioWr) {ioLastAddr, ioLast} <= {ioWrAddr, ioWrData};
      end
   end
   // io reads are live; writes are only recorded for the bench
   initial foreach (io[i]) io[i] = 8'h00;
   assign ioRdData = io[ioAddr];
endmodule : cbt_mem_model
`default_nettype wire
